// ---- pkg/pmc_consts.vh ----
// constants for the operating-mode controller: register map, fields, codes
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// register byte addresses
`define PMC_ADDR_SYSCLK 4'h0
`define PMC_ADDR_LXT 4'h4
`define PMC_ADDR_HXT 4'h8
`define PMC_ADDR_HIGHSPEED_RC_OSC 4'hC
`define PMC_ADDR_STATUS 8'h10
`define PMC_ADDR_WAKE 8'h14
`define PMC_ADDR_W 8

// system clock control fields
`define PMC_CKS_HI 7
`define PMC_CKS_LO 5
`define PMC_HFSEL_BIT 3
`define PMC_LFSEL_BIT 2
`define PMC_HKEEP_BIT 1
`define PMC_LKEEP_BIT 0
`define PMC_CKS_SUB 3'h7
`define PMC_SYSCLK_RST 8'h00

// oscillator control fields (enable, stable flag)
`define PMC_EN_BIT 0
`define PMC_STABLE_BIT 1
`define PMC_HIGHSPEED_RC_OSC_EN_RST 1'b1
`define PMC_REG_RST 8'h00

// oscillator index into the four-wide vectors
`define PMC_OSC_HIGHSPEED_RC_OSC 0
`define PMC_OSC_HXT 1
`define PMC_OSC_LOWSPEED_RC_OSC 2
`define PMC_OSC_LXT 3
`define PMC_NOSC 4

// status fields
`define PMC_PDF_BIT 0
`define PMC_TO_BIT 1
`define PMC_MODE_LO 2
`define PMC_MODE_HI 4
`define PMC_HOLD_BIT 5

// mode codes shown in status
`define PMC_MODE_FAST 3'h0
`define PMC_MODE_SLOW 3'h1
`define PMC_MODE_SLEEP 3'h2
`define PMC_MODE_IDLE_ZERO_MODE 3'h3
`define PMC_MODE_IDLE_ONE_MODE 3'h4
`define PMC_MODE_IDLE_TWO_MODE 3'h5
`define PMC_MODE_WAKE 3'h6

// misc widths and answers
`define PMC_PORTA_W 8
`define PMC_INT_W 8
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`define PMC_ZERO32 32'h0000_0000

`endif

// ---- hw/pmc_power_mode_controller.v ----
// operating-mode controller: fast/slow/sleep/idle modes, oscillators, wake-up
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pmc_consts.vh"

module pmc_power_mode_controller (
   // clock and reset
   input wire clk,
   input wire nrst,
   // axi4-lite write address and data
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // core events, same clock
   input wire haltExec,
   input wire clearWatchdogExec,
   input wire watchdogEnabled,
   input wire watchdogOverflow,
   input wire [`PMC_INT_W-1:0] intRequest,
   // pins and analog ready levels, asynchronous
   input wire [`PMC_PORTA_W-1:0] portAPin,
   input wire extResetN,
   input wire [`PMC_NOSC-1:0] oscReady,
   // oscillator and clock control
   output reg [`PMC_NOSC-1:0] oscEnable,
   output reg [2:0] sysClockDivSel,
   output reg sysClockUseSub,
   output reg fastClockRun,
   output reg subClockRun,
   // core control
   output reg coreHold,
   output reg watchdogClear,
   output reg pcSpReset,
   output reg haltResume
);

   // one-hot states
   localparam [5:0] ST_RUN = 6'h01;
   localparam [5:0] ST_SLEEP = 6'h02;
   localparam [5:0] ST_IDLE_ZERO_MODE = 6'h04;
   localparam [5:0] ST_IDLE_ONE_MODE = 6'h08;
   localparam [5:0] ST_IDLE_TWO_MODE = 6'h10;
   localparam [5:0] ST_WAKE = 6'h20;

   // software-visible control
   reg [2:0] clockSelect;
   reg highFreqSelect;
   reg lowfreqSourceSelect;
   reg highspeedKeepalive;
   reg lowspeedKeepalive;
   reg lowspeedCrystalEnable;
   reg highspeedCrystalEnable;
   reg highspeedRcEnable;
   reg [`PMC_PORTA_W-1:0] portAWakeEnable;
   reg powerDownFlag;
   reg watchdogTimeoutFlag;

   // internal state
   reg [5:0] state;
   reg [5:0] next_state;
   reg [`PMC_NOSC-1:0] oscStable;
   reg [`PMC_NOSC-1:0] oscEnablePrev;
   reg [`PMC_INT_W-1:0] intPendingAtHalt;
   reg [`PMC_PORTA_W-1:0] portAPrev;

   // synchronisers: first stage read only by second stage
   reg [`PMC_PORTA_W-1:0] portAMeta;
   reg [`PMC_PORTA_W-1:0] portASync;
   reg extRstMeta;
   reg extRstSyncN;
   reg [`PMC_NOSC-1:0] readyMeta;
   reg [`PMC_NOSC-1:0] readySync;

   // axi bookkeeping
   reg [`PMC_ADDR_W-1:0] wrAddr;
   reg [31:0] wrData;
   reg [3:0] wrStrb;
   reg haveAddr;
   reg haveData;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // register read mux, used by the read channel and for mapping checks
   function [32:0] regRead;
      input [`PMC_ADDR_W-1:0] addr;
      input [31:0] sysclk;
      input [31:0] lowspeed_crystal_osc;
      input [31:0] highspeed_crystal_osc;
      input [31:0] highspeed_rc_osc;
      input [31:0] stat;
      input [31:0] wake;
      begin
         case (addr)
            {4'h0, `PMC_ADDR_SYSCLK}: regRead = {1'b1, sysclk};
            {4'h0, `PMC_ADDR_LXT}: regRead = {1'b1, lowspeed_crystal_osc};
            {4'h0, `PMC_ADDR_HXT}: regRead = {1'b1, highspeed_crystal_osc};
            {4'h0, `PMC_ADDR_HIGHSPEED_RC_OSC}: regRead = {1'b1, highspeed_rc_osc};
            `PMC_ADDR_STATUS: regRead = {1'b1, stat};
            `PMC_ADDR_WAKE: regRead = {1'b1, wake};
            default: regRead = {1'b0, `PMC_ZERO32};
         endcase
      end
   endfunction

   // mode code for status
   function [2:0] modeCode;
      input [5:0] st;
      input useSub;
      begin
         case (st)
            ST_RUN: modeCode = useSub ? `PMC_MODE_SLOW : `PMC_MODE_FAST;
            ST_SLEEP: modeCode = `PMC_MODE_SLEEP;
            ST_IDLE_ZERO_MODE: modeCode = `PMC_MODE_IDLE_ZERO_MODE;
            ST_IDLE_ONE_MODE: modeCode = `PMC_MODE_IDLE_ONE_MODE;
            ST_IDLE_TWO_MODE: modeCode = `PMC_MODE_IDLE_TWO_MODE;
            default: modeCode = `PMC_MODE_WAKE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register views

   wire [31:0] sysclkView = {24'h00_0000, clockSelect, 1'b0, highFreqSelect,
      lowfreqSourceSelect, highspeedKeepalive, lowspeedKeepalive};
   // upper bits of oscillator controls stay zero
   wire [31:0] lxtView = {30'h0000_0000, oscStable[`PMC_OSC_LXT],
      lowspeedCrystalEnable};
   wire [31:0] hxtView = {30'h0000_0000, oscStable[`PMC_OSC_HXT],
      highspeedCrystalEnable};
   wire [31:0] hircView = {30'h0000_0000, oscStable[`PMC_OSC_HIGHSPEED_RC_OSC], highspeedRcEnable};
   wire [31:0] statusView = {26'h000_0000, coreHold, modeCode(state, sysClockUseSub),
      watchdogTimeoutFlag, powerDownFlag};
   wire [31:0] wakeView = {24'h00_0000, portAWakeEnable};

   wire wrFire = haveAddr && haveData && !s_axi_bvalid;
   wire [32:0] wrHit = regRead(wrAddr, sysclkView, lxtView, hxtView, hircView,
      statusView, wakeView);
   wire [32:0] rdHit = regRead(s_axi_araddr[`PMC_ADDR_W-1:0], sysclkView, lxtView,
      hxtView, hircView, statusView, wakeView);
   wire upperZero = (s_axi_araddr[31:`PMC_ADDR_W] == 24'h00_0000);

   ////////////////////////////////////////////////////////////////////////
   // derived conditions

   wire halted = state[1] | state[2] | state[3] | state[4];
   wire fastStable = highFreqSelect ? oscStable[`PMC_OSC_HXT] : oscStable[`PMC_OSC_HIGHSPEED_RC_OSC];
   wire slowStable = lowfreqSourceSelect ? oscStable[`PMC_OSC_LXT] :
      oscStable[`PMC_OSC_LOWSPEED_RC_OSC];
   wire wantSub = (clockSelect == `PMC_CKS_SUB);
   // falling edge on an enabled port a pin
   wire portWake = |(portAPrev & ~portASync & portAWakeEnable);
   // requests already pending at halt are excluded from waking
   wire intWake = |(intRequest & ~intPendingAtHalt);
   wire wakeEvent = portWake | !extRstSyncN | intWake | watchdogOverflow;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (haltExec) begin
               case ({highspeedKeepalive, lowspeedKeepalive})
                  2'b00: next_state = ST_SLEEP;
                  2'b01: next_state = ST_IDLE_ZERO_MODE;
                  2'b11: next_state = ST_IDLE_ONE_MODE;
                  default: next_state = ST_IDLE_TWO_MODE;
               endcase
            end
         end
         ST_SLEEP, ST_IDLE_ZERO_MODE, ST_IDLE_ONE_MODE, ST_IDLE_TWO_MODE: begin
            if (wakeEvent) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            // core stays held until the running system clock is stable
            if (sysClockUseSub ? slowStable : fastStable) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator enables; a stopped clock restarts on wake, or in run when clockSelect leaves sub or highspeedKeepalive is set

   reg [`PMC_NOSC-1:0] next_oscEnable;
   reg nextFastOn;
   reg nextSubOn;
   always @* begin
      nextFastOn = 1'b1;
      nextSubOn = 1'b1;
      case (next_state)
         ST_SLEEP: begin
            nextFastOn = 1'b0;
            nextSubOn = 1'b0;
         end
         ST_IDLE_ZERO_MODE: nextFastOn = 1'b0;
         ST_IDLE_TWO_MODE: nextSubOn = 1'b0;
         ST_RUN: nextFastOn = !sysClockUseSub || highspeedKeepalive || !wantSub;
         default: nextFastOn = 1'b1;
      endcase
      next_oscEnable[`PMC_OSC_HIGHSPEED_RC_OSC] = highspeedRcEnable && nextFastOn && !highFreqSelect;
      next_oscEnable[`PMC_OSC_HXT] = highspeedCrystalEnable && nextFastOn;
      next_oscEnable[`PMC_OSC_LXT] = lowspeedCrystalEnable && nextSubOn;
      // watchdog keeps the low-speed rc alive regardless of keepalive
      next_oscEnable[`PMC_OSC_LOWSPEED_RC_OSC] = (nextSubOn && !lowfreqSourceSelect)
         || watchdogEnabled;
   end

   ////////////////////////////////////////////////////////////////////////
   // stable flags: cleared on enable, set once settled

   genvar gi;
   generate
      for (gi = 0; gi < `PMC_NOSC; gi = gi + 1) begin : gStable
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               oscStable[gi] <= 1'b0;
            end else if (!oscEnable[gi] || !oscEnablePrev[gi]) begin
               oscStable[gi] <= 1'b0;
            end else if (readySync[gi]) begin
               oscStable[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers and edge history

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         portAMeta <= 8'hFF;
         portASync <= 8'hFF;
         portAPrev <= 8'hFF;
         extRstMeta <= 1'b1;
         extRstSyncN <= 1'b1;
         readyMeta <= 4'h0;
         readySync <= 4'h0;
      end else begin
         portAMeta <= portAPin;
         portASync <= portAMeta;
         portAPrev <= portASync;
         extRstMeta <= extResetN;
         extRstSyncN <= extRstMeta;
         readyMeta <= oscReady;
         readySync <= readyMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode state, clock routing and core control

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_RUN;
         oscEnable <= 4'h0;
         oscEnablePrev <= 4'h0;
         sysClockDivSel <= 3'h0;
         sysClockUseSub <= 1'b0;
         fastClockRun <= 1'b1;
         subClockRun <= 1'b1;
         coreHold <= 1'b0;
         watchdogClear <= 1'b0;
         pcSpReset <= 1'b0;
         haltResume <= 1'b0;
         intPendingAtHalt <= 8'h00;
      end else begin
         state <= next_state;
         oscEnable <= next_oscEnable;
         oscEnablePrev <= oscEnable;
         fastClockRun <= !(next_state == ST_SLEEP || next_state == ST_IDLE_ZERO_MODE);
         subClockRun <= !(next_state == ST_SLEEP || next_state == ST_IDLE_TWO_MODE);
         // execution halts; memory, registers and ports untouched
         coreHold <= (next_state != ST_RUN);
         watchdogClear <= (state == ST_RUN) && haltExec;
         // the wake wait still counts as halted: no full reset there either
         pcSpReset <= (state != ST_RUN) && watchdogOverflow;
         // port, masked interrupt and other wakes resume after halt
         haltResume <= (state == ST_WAKE) && (next_state == ST_RUN);
         if ((state == ST_RUN) && haltExec) begin
            intPendingAtHalt <= intRequest;
         end
         // clock switching only when the target source is stable
         if (state == ST_RUN) begin
            if (wantSub && slowStable) begin
               sysClockUseSub <= 1'b1;
            end else if (!wantSub && (fastStable || !sysClockUseSub)) begin
               sysClockUseSub <= 1'b0;
               sysClockDivSel <= clockSelect;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power-down and timeout flags; setting beats clearing

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         powerDownFlag <= 1'b0;
         watchdogTimeoutFlag <= 1'b0;
      end else begin
         if ((state == ST_RUN) && haltExec) begin
            powerDownFlag <= 1'b1;
         end else if (clearWatchdogExec) begin
            powerDownFlag <= 1'b0;
         end
         if (watchdogOverflow) begin
            watchdogTimeoutFlag <= 1'b1;
         end else if ((state == ST_RUN) && haltExec) begin
            watchdogTimeoutFlag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: address and data in either order

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMC_RESP_OKAY;
         haveAddr <= 1'b0;
         haveData <= 1'b0;
         wrAddr <= 8'h00;
         wrData <= `PMC_ZERO32;
         wrStrb <= 4'h0;
         clockSelect <= 3'h0;
         highFreqSelect <= 1'b0;
         lowfreqSourceSelect <= 1'b0;
         highspeedKeepalive <= 1'b0;
         lowspeedKeepalive <= 1'b0;
         lowspeedCrystalEnable <= 1'b0;
         highspeedCrystalEnable <= 1'b0;
         highspeedRcEnable <= `PMC_HIGHSPEED_RC_OSC_EN_RST;
         portAWakeEnable <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wrAddr <= (s_axi_awaddr[31:`PMC_ADDR_W] == 24'h00_0000) ?
               s_axi_awaddr[`PMC_ADDR_W-1:0] : 8'hFF;
            haveAddr <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
            haveData <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wrFire) begin
            haveAddr <= 1'b0;
            haveData <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit[32] ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            // only the low byte holds fields; stable flags are read-only
            if (wrStrb[0]) begin
               case (wrAddr)
                  {4'h0, `PMC_ADDR_SYSCLK}: begin
                     clockSelect <= wrData[`PMC_CKS_HI:`PMC_CKS_LO];
                     highFreqSelect <= wrData[`PMC_HFSEL_BIT];
                     lowfreqSourceSelect <= wrData[`PMC_LFSEL_BIT];
                     highspeedKeepalive <= wrData[`PMC_HKEEP_BIT];
                     lowspeedKeepalive <= wrData[`PMC_LKEEP_BIT];
                  end
                  {4'h0, `PMC_ADDR_LXT}: lowspeedCrystalEnable <= wrData[`PMC_EN_BIT];
                  {4'h0, `PMC_ADDR_HXT}: highspeedCrystalEnable <= wrData[`PMC_EN_BIT];
                  {4'h0, `PMC_ADDR_HIGHSPEED_RC_OSC}: highspeedRcEnable <= wrData[`PMC_EN_BIT];
                  `PMC_ADDR_WAKE: portAWakeEnable <= wrData[`PMC_PORTA_W-1:0];
                  default: wrStrb <= 4'h0;
               endcase
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel: one cycle from address to data

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `PMC_ZERO32;
         s_axi_rresp <= `PMC_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= upperZero ? rdHit[31:0] : `PMC_ZERO32;
            s_axi_rresp <= (upperZero && rdHit[32]) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // pmc_power_mode_controller

// ---- testbench/pmc_monitor.sv ----
// checker of port timing for the operating-mode controller
`timescale 1ns/1ps
`include "pmc_consts.vh"

module pmc_monitor (
   // clock and reset
   input wire clk,
   input wire nrst,
   // register bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // core events
   input wire haltExec,
   input wire watchdogEnabled,
   input wire watchdogOverflow,
   // controller outputs
   input wire [`PMC_NOSC-1:0] oscEnable,
   input wire coreHold,
   input wire watchdogClear,
   input wire pcSpReset,
   input wire haltResume
);

////////////////////////////////////////////////////////////////////////////////
// one domain, so clock and reset are given once
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);

// halt entry stops the core and clears the watchdog as a single pulse
a_halt_hold: assert property (haltExec && !coreHold |=> coreHold)
   else $error("core not held after halt");
a_halt_wdclr: assert property (haltExec && !coreHold |=> watchdogClear ##1 !watchdogClear)
   else $error("watchdog clear pulse missing after halt");
a_clear_cause: assert property (watchdogClear |-> $past(haltExec) && !$past(coreHold))
   else $error("watchdog clear without halt");

// leaving the hold always comes with the resume pulse, and only from a hold
a_resume_release: assert property ($fell(coreHold) |-> haltResume)
   else $error("core released without resume pulse");
a_resume_held: assert property (haltResume |-> $past(coreHold))
   else $error("resume pulse while running");

// watchdog overflow while halted resets pc and sp, never while running
a_pcsp_halted: assert property (pcSpReset |-> $past(coreHold))
   else $error("pc reset outside halt");
a_wd_wake: assert property (coreHold && watchdogOverflow |-> ##[1:3] pcSpReset)
   else $error("no pc reset after watchdog overflow");

// low-speed rc kept alive for the watchdog
a_lowspeed_rc_osc_keep: assert property (nrst && watchdogEnabled |=> oscEnable[`PMC_OSC_LOWSPEED_RC_OSC])
   else $error("lowspeed_rc_osc stopped while watchdog enabled");

// write answers two edges after acceptance, read answers on the next edge
a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
   && s_axi_wready |=> ##1 s_axi_bvalid)
   else $error("write response late");
a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
   else $error("read data late");

endmodule // pmc_monitor

bind pmc_power_mode_controller pmc_monitor pmc_monitor_i (.clk, .nrst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .haltExec, .watchdogEnabled, .watchdogOverflow,
   .oscEnable, .coreHold, .watchdogClear, .pcSpReset, .haltResume);

// ---- testbench/tb_power_mode_controller.sv ----
// testbench for the operating-mode controller
`timescale 1ns/1ps
`include "pmc_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin nFail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_power_mode_controller;
   // design inputs, all given a value at time zero
   logic clk = 1'b0, nrst = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'hF, oscReady = 4'h7;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic haltExec = 0, clearWatchdogExec = 0, watchdogEnabled = 1, watchdogOverflow = 0;
   logic [7:0] intRequest = 8'h00, portAPin = 8'hFF;
   logic extResetN = 1'b1;
   // design outputs
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [3:0] oscEnable;
   logic [2:0] sysClockDivSel;
   logic sysClockUseSub, fastClockRun, subClockRun;
   logic coreHold, watchdogClear, pcSpReset, haltResume;
   // bench state
   int nFail = 0, compares = 0, k, n;
   logic [31:0] rd;
   logic [1:0] rr;
   logic pc;
   logic [2:0] modeTab [4] = '{3'h2, 3'h3, 3'h5, 3'h4};

   pmc_power_mode_controller pmc_power_mode_controller_i (.clk, .nrst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .haltExec, .clearWatchdogExec, .watchdogEnabled, .watchdogOverflow,
      .intRequest, .portAPin, .extResetN, .oscReady, .oscEnable, .sysClockDivSel,
      .sysClockUseSub, .fastClockRun, .subClockRun, .coreHold, .watchdogClear,
      .pcSpReset, .haltResume);

   // 50 MHz
   always #10 clk = ~clk;

////////////////////////////////////////////////////////////////////////////////
   task final_report;
      begin
         $display("compares=%0d fails=%0d", compares, nFail);
         if (nFail == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   task timeOut;
      begin
         nFail++;
         $display("hang cut short at t=%0t", $time);
         final_report;
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic axiWrite(input [7:0] a, input [7:0] d, output [1:0] r);
      begin
         @(posedge clk);
         s_axi_awaddr <= {24'h00_0000, a};
         s_axi_wdata <= {24'h00_0000, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
         end
         s_axi_bready <= 1'b0;
         r = s_axi_bresp;
         if (n == 50) timeOut;
      end
   endtask

   task automatic axiRead(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge clk);
         s_axi_araddr <= {24'h00_0000, a};
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
         end
         s_axi_rready <= 1'b0;
         d = s_axi_rdata;
         r = s_axi_rresp;
         if (n == 50) timeOut;
      end
   endtask

   task automatic rdChk(input [7:0] a, input [31:0] e);
      begin
         axiRead(a, rd, rr);
         `CHK(rr, `PMC_RESP_OKAY)
         `CHK(rd, e)
      end
   endtask

   // bounded wait for the resume pulse, noting any pc reset on the way
   task automatic waitResume;
      begin
         pc = 1'b0;
         for (n = 0; n < 300; n++) begin
            @(posedge clk);
            if (pcSpReset === 1'b1) pc = 1'b1;
            if (haltResume === 1'b1) break;
         end
         if (n == 300) timeOut;
      end
   endtask

////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      // power-up values and unmapped places
      rdChk(`PMC_ADDR_LXT, 32'h0000_0000);
      rdChk(`PMC_ADDR_STATUS, 32'h0000_0000);
      axiRead(8'h18, rd, rr);
      `CHK(rr, `PMC_RESP_SLVERR)
      axiWrite(8'h1C, 8'hFF, rr);
      `CHK(rr, `PMC_RESP_SLVERR)
      $display("test regs done");
      // lxt: only the enable is writable, stable waits for the oscillator
      axiWrite(`PMC_ADDR_LXT, 8'hFF, rr);
      rdChk(`PMC_ADDR_LXT, 32'h0000_0001);
      `CHK(oscEnable[`PMC_OSC_LXT], 1'b1)
      oscReady[`PMC_OSC_LXT] <= 1'b1;
      repeat (6) @(posedge clk);
      rdChk(`PMC_ADDR_LXT, 32'h0000_0003);
      $display("test lxt done");
      // slow mode on lxt, then back to fast once highspeed_rc_osc restarts
      axiWrite(`PMC_ADDR_SYSCLK, 8'hE4, rr);
      for (n = 0; n < 50 && sysClockUseSub !== 1'b1; n++) @(posedge clk);
      `CHK(sysClockUseSub, 1'b1)
      rdChk(`PMC_ADDR_STATUS, 32'h0000_0004);
      oscReady[`PMC_OSC_HIGHSPEED_RC_OSC] <= 1'b0;
      axiWrite(`PMC_ADDR_SYSCLK, 8'h44, rr);
      repeat (10) @(posedge clk);
      `CHK(sysClockUseSub, 1'b1)
      oscReady[`PMC_OSC_HIGHSPEED_RC_OSC] <= 1'b1;
      for (n = 0; n < 50 && sysClockUseSub !== 1'b0; n++) @(posedge clk);
      `CHK(sysClockUseSub, 1'b0)
      `CHK(sysClockDivSel, 3'h2)
      for (k = 0; k < 7; k++) begin
         axiWrite(`PMC_ADDR_SYSCLK, {k[2:0], 5'h04}, rr);
         for (n = 0; n < 20 && sysClockDivSel !== k[2:0]; n++) @(posedge clk);
         `CHK(sysClockDivSel, k[2:0])
      end
      $display("test clock switch done");
      // each keep-alive pair, woken by port, reset pin, interrupt, watchdog
      axiWrite(`PMC_ADDR_WAKE, 8'h01, rr);
      for (k = 0; k < 4; k++) begin
         axiWrite(`PMC_ADDR_SYSCLK, {6'h01, k[1:0]}, rr);
         if (k == 2) intRequest <= 8'h01;
         @(posedge clk);
         haltExec <= 1'b1;
         @(posedge clk);
         haltExec <= 1'b0;
         @(posedge clk);
         `CHK(coreHold, 1'b1)
         `CHK(fastClockRun, k[1])
         `CHK(subClockRun, k[0])
         if (k == 0) begin
            `CHK(oscEnable[`PMC_OSC_LOWSPEED_RC_OSC], 1'b1)
            watchdogEnabled <= 1'b0;
            repeat (2) @(posedge clk);
            `CHK(oscEnable[`PMC_OSC_LOWSPEED_RC_OSC], 1'b0)
            watchdogEnabled <= 1'b1;
         end
         rdChk(`PMC_ADDR_STATUS, {26'h000_0000, 1'b1, modeTab[k], 2'b01});
         case (k)
            0: portAPin <= 8'hFE;
            1: extResetN <= 1'b0;
            2: begin
               repeat (8) @(posedge clk);
               `CHK(coreHold, 1'b1)
               intRequest <= 8'h03;
            end
            default: begin
               watchdogOverflow <= 1'b1;
               @(posedge clk);
               watchdogOverflow <= 1'b0;
            end
         endcase
         waitResume;
         `CHK(pc, (k == 3))
         portAPin <= 8'hFF;
         extResetN <= 1'b1;
         intRequest <= 8'h00;
      end
      rdChk(`PMC_ADDR_STATUS, 32'h0000_0003);
      @(posedge clk);
      clearWatchdogExec <= 1'b1;
      @(posedge clk);
      clearWatchdogExec <= 1'b0;
      rdChk(`PMC_ADDR_STATUS, 32'h0000_0002);
      // halt with the timeout flag still set: halt must clear it
      @(posedge clk);
      haltExec <= 1'b1;
      @(posedge clk);
      haltExec <= 1'b0;
      rdChk(`PMC_ADDR_STATUS, 32'h0000_0031);
      portAPin <= 8'hFE;
      waitResume;
      portAPin <= 8'hFF;
      $display("test halt and wake done");
      final_report;
   end
endmodule // tb_power_mode_controller
